// ### rtl/vlsr_top.sv
// Variable length serial shift register, 1 to 64 stages, with pin front end.
// Assumes all pins are asynchronous to clock; master_reset acts without it.
`default_nettype none
module vlsr_top #(
   parameter int DEPTH = vlsr_pkg::DEPTH,
   parameter int LEN_W = vlsr_pkg::LEN_W
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic master_reset,
   input wire logic shift_clock,
   input wire logic shift_hold,
   input wire logic data_a,
   input wire logic data_b,
   input wire logic select_a,
   input wire logic len_weight_one,
   input wire logic len_weight_two,
   input wire logic len_weight_four,
   input wire logic len_weight_eight,
   input wire logic len_weight_sixteen,
   input wire logic len_weight_thirtytwo,
   output logic serial_out,
   output logic serial_out_n
);
   localparam int PIN_W = vlsr_pkg::PIN_W;

   typedef struct packed {
      logic [PIN_W-1:0] sync1;
      logic [PIN_W-1:0] sync2;
      logic [PIN_W-1:0] sync3;
      logic [PIN_W-1:0] filt;
      logic shift;
      logic shift_in;
   } vlsr_front_s;

   vlsr_front_s state;
   vlsr_front_s next_state;
   logic [PIN_W-1:0] pins;
   logic chain_rst_n;
   logic clk_rise;
   logic hold_fall;
   logic sel_data;

   if (LEN_W != vlsr_pkg::LEN_W) begin : g_bad_width
      $error("LEN_W must match the six weighted length pins");
   end

   vlsr_chain_if #(.LEN_W(LEN_W)) ch ();

   // Returns the filtered pin value; a change counts once stages two and three agree
   function automatic logic [PIN_W-1:0] vlsr_filter(
      input logic [PIN_W-1:0] prev,
      input logic [PIN_W-1:0] s2,
      input logic [PIN_W-1:0] s3
   );
      logic [PIN_W-1:0] res;
      res = prev;
      for (int i = 0; i < PIN_W; i++) begin
         if (s2[i] == s3[i]) begin
            res[i] = s2[i];
         end
      end
      return res;
   endfunction : vlsr_filter

   // Weights sit at their binary place, so len is the sum of asserted weights
   assign pins = {shift_clock, shift_hold, data_a, data_b, select_a,
                  len_weight_thirtytwo, len_weight_sixteen, len_weight_eight,
                  len_weight_four, len_weight_two, len_weight_one}; // R02

   // Master reset is folded into the chain reset so it needs no clock edge.
   // Its release is not synchronised; hold data steady around it.
   assign chain_rst_n = arst_n & ~master_reset; // R06

   always_comb begin
      next_state = state;
      next_state.sync1 = pins;
      next_state.sync2 = state.sync1;
      next_state.sync3 = state.sync2;
      next_state.filt = vlsr_filter(state.filt, state.sync2, state.sync3);
      // Rising clock with enable low, or enable falling while clock stays high
      clk_rise = next_state.filt[vlsr_pkg::PIN_CLK] & ~state.filt[vlsr_pkg::PIN_CLK]; // R10
      hold_fall = ~next_state.filt[vlsr_pkg::PIN_HOLD] & state.filt[vlsr_pkg::PIN_HOLD]; // R05
      // Data taken as it stood before the edge, which keeps setup meaningful
      sel_data = state.filt[vlsr_pkg::PIN_SEL] ? state.filt[vlsr_pkg::PIN_A]
                                               : state.filt[vlsr_pkg::PIN_B]; // R03
      next_state.shift = (clk_rise & ~next_state.filt[vlsr_pkg::PIN_HOLD]) // R04
                         | (hold_fall & next_state.filt[vlsr_pkg::PIN_CLK]); // R05
      next_state.shift_in = sel_data;
      // Shift requests during master reset are dropped
      if (master_reset) begin // R06
         next_state.shift = 1'h0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state.sync1 <= vlsr_pkg::PIN_RESET;
         state.sync2 <= vlsr_pkg::PIN_RESET;
         state.sync3 <= vlsr_pkg::PIN_RESET;
         state.filt <= vlsr_pkg::PIN_RESET;
         state.shift <= 1'h0;
         state.shift_in <= 1'h0;
      end else begin
         state <= next_state;
      end
   end

   assign ch.shift = state.shift;
   assign ch.shift_in = state.shift_in;
   assign ch.len = state.filt[vlsr_pkg::PIN_LEN_LSB +: LEN_W]; // R01

   vlsr_chain #(
      .DEPTH(DEPTH),
      .LEN_W(LEN_W)
   ) u_chain (
      .clock(clock),
      .rst_n(chain_rst_n),
      .ch(ch.chain)
   );

   assign serial_out = ch.tap; // R07
   assign serial_out_n = ch.tap_n; // R11

   // Named steps of a shift, and the quiet case with neither a shift nor master reset
   sequence clk_rise_seq;
      !$past(state.filt[vlsr_pkg::PIN_CLK]) && state.filt[vlsr_pkg::PIN_CLK];
   endsequence

   sequence hold_fall_seq;
      $past(state.filt[vlsr_pkg::PIN_HOLD]) && !state.filt[vlsr_pkg::PIN_HOLD];
   endsequence

   sequence quiet_seq;
      !master_reset && !state.shift;
   endsequence

   sequence len_two_shift_seq;
      state.shift && ch.len == 6'h01;
   endsequence

   a_out_inverse: assert property (@(posedge clock) disable iff (!arst_n) // R11
      serial_out_n == !serial_out)
      else $error("inverted output does not complement true output");

   a_reset_clears: assert property (@(posedge clock) disable iff (!arst_n) // R06
      master_reset ##1 master_reset |-> !serial_out && serial_out_n)
      else $error("master reset did not clear output");

   a_reset_blocks: assert property (@(posedge clock) disable iff (!arst_n) // R06
      master_reset |=> !state.shift)
      else $error("shift requested during master reset");

   a_rise_shifts: assert property (@(posedge clock) disable iff (!arst_n) // R04
      clk_rise_seq ##0 !state.filt[vlsr_pkg::PIN_HOLD] ##0 !$past(master_reset) |-> state.shift)
      else $error("clock rise with enable low gave no shift");

   a_hold_blocks: assert property (@(posedge clock) disable iff (!arst_n) // R05
      clk_rise_seq ##0 state.filt[vlsr_pkg::PIN_HOLD] ##0 $past(state.filt[vlsr_pkg::PIN_HOLD])
      |-> !state.shift)
      else $error("clock edge shifted while enable high");

   a_enable_fall: assert property (@(posedge clock) disable iff (!arst_n) // R05
      hold_fall_seq ##0 state.filt[vlsr_pkg::PIN_CLK] ##0 !$past(master_reset) |-> state.shift)
      else $error("enable fall with clock high gave no shift");

   a_sel_source: assert property (@(posedge clock) disable iff (!arst_n) // R03
      $rose(state.shift) |-> state.shift_in == ($past(state.filt[vlsr_pkg::PIN_SEL])
         ? $past(state.filt[vlsr_pkg::PIN_A]) : $past(state.filt[vlsr_pkg::PIN_B])))
      else $error("shift input from wrong data pin");

   // Chain stages are probed directly for lengths two and 64; the tap alone cannot show a wrong length
   a_len_one: assert property (@(posedge clock) disable iff (!chain_rst_n) // R07
      state.shift && ch.len == '0 |=> serial_out == $past(state.shift_in))
      else $error("length one did not pass data after one shift");

   a_len_two: assert property (@(posedge clock) disable iff (!chain_rst_n) // R02
      len_two_shift_seq |=> serial_out == $past(u_chain.state.stages[0]))
      else $error("length two output mismatch");

   a_static_hold: assert property (@(posedge clock) disable iff (!chain_rst_n) // R08
      quiet_seq ##0 $stable(ch.len) |=> $stable(serial_out))
      else $error("contents changed without a shift");

   a_filter_agree: assert property (@(posedge clock) disable iff (!arst_n) // R10
      $changed(state.filt[vlsr_pkg::PIN_CLK]) |-> $past(state.sync2[vlsr_pkg::PIN_CLK])
         == $past(state.sync3[vlsr_pkg::PIN_CLK]))
      else $error("clock pin accepted before sync stages agreed");

   a_len_range: assert property (@(posedge clock) disable iff (!chain_rst_n) // R01
      state.shift && ch.len == 6'h3F |=> serial_out == $past(u_chain.state.stages[DEPTH-2]))
      else $error("longest length did not tap last stage");

   a_async_clear: assert property (@(posedge clock) disable iff (!arst_n) // R06
      master_reset |-> !serial_out && serial_out_n)
      else $error("output not cleared while master reset high");

   a_clear_stages: assert property (@(posedge clock) disable iff (!arst_n) // R06
      master_reset |-> u_chain.state.stages == '0)
      else $error("stages not cleared while master reset high");

   a_no_edge_idle: assert property (@(posedge clock) disable iff (!arst_n) // R04
      !$changed(state.filt[vlsr_pkg::PIN_CLK]) && !$changed(state.filt[vlsr_pkg::PIN_HOLD]) |-> !state.shift)
      else $error("shift without a clock or enable edge");

   a_hold_idle: assert property (@(posedge clock) disable iff (!arst_n) // R05
      state.filt[vlsr_pkg::PIN_HOLD] && $past(state.filt[vlsr_pkg::PIN_HOLD]) |-> !state.shift)
      else $error("shift while enable stayed high");

   a_shift_single: assert property (@(posedge clock) disable iff (!arst_n) // R04
      state.shift |=> !state.shift)
      else $error("shift request lasted more than one cycle");

   a_sel_agree: assert property (@(posedge clock) disable iff (!arst_n) // R03
      $changed(state.filt[vlsr_pkg::PIN_SEL]) |-> $past(state.sync2[vlsr_pkg::PIN_SEL])
         == $past(state.sync3[vlsr_pkg::PIN_SEL]))
      else $error("select pin accepted before sync stages agreed");

   a_hold_agree: assert property (@(posedge clock) disable iff (!arst_n) // R05
      $changed(state.filt[vlsr_pkg::PIN_HOLD]) |-> $past(state.sync2[vlsr_pkg::PIN_HOLD])
         == $past(state.sync3[vlsr_pkg::PIN_HOLD]))
      else $error("enable pin accepted before sync stages agreed");
endmodule : vlsr_top
`default_nettype wire

// ### rtl/vlsr_pkg.sv
// Constants shared by the variable length shift register and its stage chain.
// Assumes one 200 MHz clock and pins sampled asynchronously to it.
// Functional notes
// R01: Shift length programmable from 1 to 64
// R02: Length is one plus asserted weight sum
// R03: Select high takes data A, low B
// R04: Clock edge shifts when enable held low
// R05: Enable falling with clock high shifts once
// R06: Master reset clears at once, overrides all
// R07: Output shows last stage of chosen length
// R08: Contents hold indefinitely without shift events
// R09: Outside logic may recirculate output into input
// R10: Rising clock edge is the active edge
// R11: Inverted output always complements true output
`default_nettype none
package vlsr_pkg;
   localparam int DEPTH = 64;
   localparam int LEN_W = 6;
   localparam int PIN_W = 11;
   // Positions within the sampled pin vector
   localparam int PIN_CLK = 10;
   localparam int PIN_HOLD = 9;
   localparam int PIN_A = 8;
   localparam int PIN_B = 7;
   localparam int PIN_SEL = 6;
   localparam int PIN_LEN_LSB = 0;
   localparam logic [PIN_W-1:0] PIN_RESET = 11'h000;
   localparam logic STAGE_RESET = 1'h0;
endpackage : vlsr_pkg
`default_nettype wire

// ### rtl/vlsr_chain_if.sv
// Carrier between the pin front end and the stage chain.
// Assumes both ends share one clock.
`default_nettype none
interface vlsr_chain_if #(
   parameter int LEN_W = vlsr_pkg::LEN_W
);
   logic shift;
   logic shift_in;
   logic [LEN_W-1:0] len;
   logic tap;
   logic tap_n;
   modport front (output shift, output shift_in, output len, input tap, input tap_n);
   modport chain (input shift, input shift_in, input len, output tap, output tap_n);
endinterface : vlsr_chain_if
`default_nettype wire

// ### rtl/vlsr_chain.sv
// Stage chain of the variable length shift register with registered tap.
// Assumes shift requests are single-cycle and len is already synchronised.
`default_nettype none
module vlsr_chain #(
   parameter int DEPTH = vlsr_pkg::DEPTH,
   parameter int LEN_W = vlsr_pkg::LEN_W
) (
   input wire logic clock,
   input wire logic rst_n,
   vlsr_chain_if.chain ch
);
   typedef struct packed {
      logic [DEPTH-1:0] stages;
      logic tap;
      logic tap_n;
   } vlsr_chain_s;

   vlsr_chain_s state;
   vlsr_chain_s next_state;

   if (DEPTH != (1 << LEN_W)) begin : g_bad_depth
      $error("DEPTH must equal two to the power LEN_W");
   end

   always_comb begin
      next_state = state;
      // Without a shift request the stages simply hold
      if (ch.shift) begin // R04
         next_state.stages = {state.stages[DEPTH-2:0], ch.shift_in};
      end
      // Stage index len is the len+1-th stage, giving lengths 1 to DEPTH
      next_state.tap = next_state.stages[ch.len]; // R07
      next_state.tap_n = ~next_state.stages[ch.len]; // R11
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin // R06
         state.stages <= '0;
         state.tap <= vlsr_pkg::STAGE_RESET;
         state.tap_n <= ~vlsr_pkg::STAGE_RESET;
      end else begin
         state <= next_state; // R08
      end
   end

   assign ch.tap = state.tap;
   assign ch.tap_n = state.tap_n;
endmodule : vlsr_chain
`default_nettype wire

// ### rtl/vlsr_placeholder_note.sv
// Intentionally empty compilation unit kept for ordering; holds no logic.
`default_nettype none
`default_nettype wire

// ### sim/vlsr_feeder.sv
// Surrounding logic model: fresh data on one input, recirculated output on the other.
// Assumes the bench sets fresh_bit at falling clock edges.
`default_nettype none
module vlsr_feeder (
   input wire logic fresh_bit,
   input wire logic serial_out,
   output logic data_a,
   output logic data_b
);
   timeunit 1ns;
   timeprecision 1ps;
   assign data_a = fresh_bit;
   // Feedback moves well after the design's hold window closes
   assign data_b = serial_out;
endmodule : vlsr_feeder
`default_nettype wire

// ### sim/tb_variable_length_shift_register.sv
// Self-checking bench for the variable length shift register.
// Assumes pins are sampled through a three flop filter, so each step waits 4 cycles.
`default_nettype none
module tb_variable_length_shift_register;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, arst_n = 0, master_reset = 0, shift_clock = 0, shift_hold = 0;
   logic select_a = 1, fresh_bit = 0;
   logic [5:0] len = 6'h00;
   logic data_a, data_b, serial_out, serial_out_n;
   int num_errors = 0, checks_done = 0, cycles = 0;
   int lens[4] = '{1, 2, 33, 64};
   always #2.5 clock = ~clock;
   vlsr_top dut (.clock(clock), .arst_n(arst_n), .master_reset(master_reset), .shift_clock(shift_clock),
      .shift_hold(shift_hold), .data_a(data_a), .data_b(data_b), .select_a(select_a),
      .len_weight_one(len[0]), .len_weight_two(len[1]), .len_weight_four(len[2]),
      .len_weight_eight(len[3]), .len_weight_sixteen(len[4]), .len_weight_thirtytwo(len[5]),
      .serial_out(serial_out), .serial_out_n(serial_out_n));
   vlsr_feeder feeder (.fresh_bit(fresh_bit), .serial_out(serial_out), .data_a(data_a), .data_b(data_b));
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : wait_cyc
   task automatic check(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask : check
   task automatic check_out(input logic exp);
      check("serial_out", exp, serial_out);
      check("serial_out_n", ~exp, serial_out_n);
   endtask : check_out
   // One shift, either by clock rising with hold low or by hold falling with clock high
   task automatic shift_bit(input logic bit_in, input logic sel, input logic by_hold);
      fresh_bit = bit_in;
      select_a = sel;
      shift_hold = by_hold;
      shift_clock = by_hold;
      wait_cyc(4);
      if (by_hold) shift_hold = 0;
      else shift_clock = 1;
      wait_cyc(4);
      shift_clock = 0;
      wait_cyc(4);
   endtask : shift_bit
   task automatic pulse_reset;
      master_reset = 1;
      wait_cyc(3);
      master_reset = 0;
      wait_cyc(3);
   endtask : pulse_reset
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   always @(posedge clock) begin
      cycles++;
      if (cycles > 5000) begin
         num_errors++;
         $display("Error timeout expected done seen running");
         end_of_test();
      end
   end
   initial begin
      wait_cyc(2);
      arst_n = 1;
      wait_cyc(2);
      // Marker bit must emerge after exactly the programmed number of shifts
      foreach (lens[i]) begin
         len = 6'(lens[i] - 1);
         pulse_reset();
         for (int k = 1; k <= lens[i]; k++) begin
            shift_bit(k == 1, 1'b1, k[0]);
            check_out(k == lens[i]);
         end
         $display("Test length %0d done", lens[i]);
      end
      len = 6'h01;
      pulse_reset();
      shift_bit(1'b1, 1'b0, 1'b0);
      check_out(1'b0);
      shift_bit(1'b1, 1'b1, 1'b0);
      check_out(1'b0);
      shift_bit(1'b0, 1'b1, 1'b0);
      check_out(1'b1);
      for (int k = 0; k < 4; k++) begin
         shift_bit(1'b0, 1'b0, k[0]);
         check_out(k[0]);
      end
      $display("Test select and recirculation done");
      shift_hold = 1;
      repeat (3) begin
         shift_clock = 1;
         wait_cyc(4);
         shift_clock = 0;
         wait_cyc(4);
      end
      wait_cyc(200);
      check_out(1'b1);
      $display("Test hold and static done");
      shift_hold = 0;
      master_reset = 1;
      #1;
      check_out(1'b0);
      wait_cyc(1);
      shift_bit(1'b1, 1'b1, 1'b0);
      check_out(1'b0);
      master_reset = 0;
      wait_cyc(3);
      $display("Test master reset done");
      end_of_test();
   end
endmodule : tb_variable_length_shift_register
`default_nettype wire
